// ==== design/gpio_port_pkg.sv ====
// Constants, types and helpers for the P0/P1/P9 port block.
// Assumes a 50 MHz ref_clk and an Avalon-MM slave with 32-bit data.
// Contract
// - P0 has four pins with own direction
// - P1 has four pins with own direction
// - Output mode drives the latch bit level
// - Direction 0 input, 1 output, reset 0
// - Pull-up only if enabled and input mode
// - P0 select bits route pins to oscillators
// - Clearing HF select with oscillator on resets
// - P0 readback zero if output or routed
// - P1 readback live if input, else zero
// - P10 is reset input until made port
// - UART1 swap bit exchanges P90 and P91
// - Don't-care settings never change pin behaviour
// - Latch value reaches pin after write cycle
package gpio_port_pkg;

    // Bus geometry
    localparam int ADDR_W = 14;
    localparam int IDX_W  = 12;
    localparam int DATA_W = 32;

    // Register indices; byte address is four times the index
    localparam logic [IDX_W-1:0] IDX_P0_LATCH  = 12'h000;
    localparam logic [IDX_W-1:0] IDX_P1_LATCH  = 12'h001;
    localparam logic [IDX_W-1:0] IDX_P9_LATCH  = 12'h009;
    localparam logic [IDX_W-1:0] IDX_P0_READ   = 12'h00d;
    localparam logic [IDX_W-1:0] IDX_P1_READ   = 12'h00e;
    localparam logic [IDX_W-1:0] IDX_P9_READ   = 12'h016;
    localparam logic [IDX_W-1:0] IDX_P0_DIR    = 12'hf1a;
    localparam logic [IDX_W-1:0] IDX_P1_DIR    = 12'hf1b;
    localparam logic [IDX_W-1:0] IDX_P9_DIR    = 12'hf23;
    localparam logic [IDX_W-1:0] IDX_P0_PU     = 12'hf27;
    localparam logic [IDX_W-1:0] IDX_P1_PU     = 12'hf28;
    localparam logic [IDX_W-1:0] IDX_P0_FSEL   = 12'hf34;
    localparam logic [IDX_W-1:0] IDX_P9_FSEL   = 12'hf3d;
    localparam logic [IDX_W-1:0] IDX_SYS_CTRL2 = 12'hf50;
    localparam logic [IDX_W-1:0] IDX_UART_SWAP = 12'hf51;

    // Field positions
    localparam int HF_SEL_BIT    = 0;
    localparam int LF_SEL_BIT    = 2;
    localparam int HF_EN_BIT     = 0;
    localparam int P10_PORT_BIT  = 1;
    localparam int UART1_SWAP_BIT = 0;

    // Implemented-bit masks
    localparam logic [7:0] PORT_MASK = 8'h0f;
    localparam logic [7:0] P9_MASK   = 8'h07;
    localparam logic [7:0] FSEL_MASK = 8'h05;
    localparam logic [7:0] SYS_MASK  = 8'h03;
    localparam logic [7:0] SWAP_MASK = 8'h01;

    // Reset values
    localparam logic [3:0] REG_RESET = 4'h0;
    localparam logic [7:0] BYTE_ZERO = 8'h00;

    // Per-port software settings
    typedef struct packed {
        logic [3:0] latch;
        logic [3:0] dir;
        logic [3:0] pu;
    } port_cfg_t;

    // Per-port pad controls
    typedef struct packed {
        logic [3:0] out;
        logic [3:0] oe;
        logic [3:0] pull;
    } pad_t;

    // Bus handshake states
    typedef enum logic {BUS_IDLE, BUS_DONE} bus_state_t;

    // Keep only implemented bits of a written byte
    function automatic logic [3:0] masked_nibble(input logic [7:0] data,
                                                 input logic [7:0] mask);
        logic [7:0] tmp;
        tmp = data & mask;
        return tmp[3:0];
    endfunction

endpackage

// ==== design/gpio_pad_ctrl.sv ====
// Pad control and readback gating for one four-pin port.
// Assumes pin inputs already synchronous to ref_clk.
`timescale 1ns/1ps
`default_nettype none
module gpio_pad_ctrl
    import gpio_port_pkg::*;
(
    input  wire port_cfg_t  cfg,
    input  wire logic [3:0] pin_in,
    input  wire logic [3:0] alt_own,
    input  wire logic [3:0] alt_oe,
    input  wire logic [3:0] alt_out,
    input  wire logic [3:0] rd_block,
    output var  pad_t       pad,
    output logic [3:0]      readback
);

    // Pin drive follows latch unless a secondary function owns it
    always_comb begin
        // Owned pins ignore the direction bit for drive, enable and pull-up
        pad.out  = (alt_own & alt_out) | (~alt_own & cfg.latch);
        pad.oe   = (alt_own & alt_oe) | (~alt_own & cfg.dir);
        // Pull-up is meaningless while driving, so it is gated off
        pad.pull = cfg.pu & ~cfg.dir & ~alt_own;
        // No input latch: the live level is returned directly
        readback = pin_in & ~cfg.dir & ~rd_block;
    end

endmodule
`default_nettype wire

// ==== design/gpio_ports.sv ====
// Top of the P0/P1/P9 port block with its Avalon-MM register slave.
// Assumes pins and bus signals synchronous to ref_clk; pads resolve
// the wire level from out, oe and pull outside this block.
`timescale 1ns/1ps
`default_nettype none
module gpio_ports
    import gpio_port_pkg::*;
(
    input  wire logic              ref_clk,
    input  wire logic              rstn,
    // Avalon-MM slave
    input  wire logic [ADDR_W-1:0] avs_address,
    input  wire logic              avs_read,
    input  wire logic              avs_write,
    input  wire logic [DATA_W-1:0] avs_writedata,
    input  wire logic [3:0]        avs_byteenable,
    output logic [DATA_W-1:0]      avs_readdata,
    output logic                   avs_waitrequest,
    // Port P0 pins
    input  wire logic [3:0]        p0_pin_in,
    output logic [3:0]             p0_pin_out,
    output logic [3:0]             p0_pin_oe,
    output logic [3:0]             p0_pin_pullup,
    // Port P1 pins
    input  wire logic [3:0]        p1_pin_in,
    output logic [3:0]             p1_pin_out,
    output logic [3:0]             p1_pin_oe,
    output logic [3:0]             p1_pin_pullup,
    // Port P9 pins
    input  wire logic [2:0]        p9_pin_in,
    output logic [2:0]             p9_pin_out,
    output logic [2:0]             p9_pin_oe,
    // Secondary functions
    output logic                   hf_osc_input,
    output logic                   lf_osc_input,
    output logic                   external_reset_in_n,
    output logic                   ext_irq5_in_n,
    output logic                   stop_release_in_n,
    input  wire logic              uart1_transmit,
    output logic                   uart1_receive,
    output logic                   sysclk_reset_req
);

    // Reset synchroniser stages
    logic       rst_meta_n;             // First stage, read by second only
    logic       rst_n;                  // Released reset for the block

    // Register state
    port_cfg_t  p0_cfg;                 // P0 latch, direction, pull-up
    port_cfg_t  p1_cfg;                 // P1 latch, direction, pull-up
    port_cfg_t  p9_cfg;                 // P9 latch, direction (no pull-up)
    logic [3:0] p0_fsel;                // Oscillator select bits
    logic [3:0] p9_fsel;                // UART output select bits
    logic [3:0] sys_ctrl2;              // Oscillator enable, P10 mode
    logic [3:0] uart_swap;              // UART1 pin swap
    logic       osc_reset;              // Registered reset request

    // Next values
    port_cfg_t  next_p0_cfg;
    port_cfg_t  next_p1_cfg;
    port_cfg_t  next_p9_cfg;
    logic [3:0] next_p0_fsel;
    logic [3:0] next_p9_fsel;
    logic [3:0] next_sys_ctrl2;
    logic [3:0] next_uart_swap;
    logic       next_osc_reset;

    // Bus state
    bus_state_t       bus_state;        // Idle or answering
    bus_state_t       next_bus_state;
    logic [7:0]       read_byte;        // Held answer byte
    logic [7:0]       next_read_byte;
    logic [7:0]       read_mux;         // Decoded read value
    logic             bus_req;          // Read or write present
    logic             commit;           // Edge at which access completes
    logic             wr_en;            // Write with low lane enabled
    logic [IDX_W-1:0] reg_idx;          // Word index of the access
    logic [7:0]       wbyte;            // Low byte of write data

    // Pad wiring
    pad_t       p0_pad;
    pad_t       p1_pad;
    pad_t       p9_pad;
    logic [3:0] p0_read;                // Gated P0 readback
    logic [3:0] p1_read;                // Gated P1 readback
    logic [3:0] p9_read;                // Gated P9 readback
    logic [3:0] p0_own;                 // P0 pins given to oscillators
    logic [3:0] p1_own;                 // P1 pins given to reset input
    logic [3:0] p9_own;                 // P9 pin given to transmit
    logic [3:0] p9_tx_out;              // Transmit level per pin
    logic       hf_sel;
    logic       lf_sel;
    logic       p10_is_port;
    logic       swap;

    // Reset release through two flops
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            rst_meta_n <= 1'b0;
            rst_n      <= 1'b0;
        end else begin
            rst_meta_n <= 1'b1;
            rst_n      <= rst_meta_n;
        end
    end

    // Decode of the current access
    always_comb begin
        bus_req = avs_read | avs_write;
        reg_idx = avs_address[ADDR_W-1:2];
        wbyte   = avs_writedata[7:0];
        // Only the answering cycle completes the access
        commit  = bus_req && (bus_state == BUS_DONE);
        // Narrow registers live in the low lane only
        wr_en   = commit && avs_write && avs_byteenable[0];
    end

    // One wait state, then the access completes
    always_comb begin
        case (bus_state)
            BUS_IDLE: begin
                // Request seen: answer on the next edge
                next_bus_state = bus_req ? BUS_DONE : BUS_IDLE;
            end
            BUS_DONE: begin
                // Always back to idle so requests cannot chain early
                next_bus_state = BUS_IDLE;
            end
            default: begin
                next_bus_state = BUS_IDLE;
            end
        endcase
        avs_waitrequest = bus_req && (bus_state != BUS_DONE);
    end

    // Read data multiplexer; unmapped addresses read zero
    always_comb begin
        case (reg_idx)
            IDX_P0_LATCH:  read_mux = {4'h0, p0_cfg.latch};
            IDX_P1_LATCH:  read_mux = {4'h0, p1_cfg.latch};
            IDX_P9_LATCH:  read_mux = {4'h0, p9_cfg.latch};
            IDX_P0_READ:   read_mux = {4'h0, p0_read};
            IDX_P1_READ:   read_mux = {4'h0, p1_read};
            IDX_P9_READ:   read_mux = {4'h0, p9_read};
            IDX_P0_DIR:    read_mux = {4'h0, p0_cfg.dir};
            IDX_P1_DIR:    read_mux = {4'h0, p1_cfg.dir};
            IDX_P9_DIR:    read_mux = {4'h0, p9_cfg.dir};
            IDX_P0_PU:     read_mux = {4'h0, p0_cfg.pu};
            IDX_P1_PU:     read_mux = {4'h0, p1_cfg.pu};
            IDX_P0_FSEL:   read_mux = {4'h0, p0_fsel};
            IDX_P9_FSEL:   read_mux = {4'h0, p9_fsel};
            IDX_SYS_CTRL2: read_mux = {4'h0, sys_ctrl2};
            IDX_UART_SWAP: read_mux = {4'h0, uart_swap};
            default:       read_mux = BYTE_ZERO;
        endcase
        // Sample in the wait cycle so data stands at the completing edge
        if (bus_state == BUS_IDLE && avs_read) begin
            next_read_byte = read_mux;
        end else begin
            next_read_byte = read_byte;
        end
    end

    // Register next values from bus writes
    always_comb begin
        next_p0_cfg    = p0_cfg;
        next_p1_cfg    = p1_cfg;
        next_p9_cfg    = p9_cfg;
        next_p0_fsel   = p0_fsel;
        next_p9_fsel   = p9_fsel;
        next_sys_ctrl2 = sys_ctrl2;
        next_uart_swap = uart_swap;
        next_osc_reset = 1'b0;
        if (wr_en) begin
            // Upper bits are dropped by the masks
            case (reg_idx)
                IDX_P0_LATCH: begin
                    next_p0_cfg.latch = masked_nibble(wbyte, PORT_MASK);
                end
                IDX_P1_LATCH: begin
                    next_p1_cfg.latch = masked_nibble(wbyte, PORT_MASK);
                end
                IDX_P9_LATCH: begin
                    next_p9_cfg.latch = masked_nibble(wbyte, P9_MASK);
                end
                IDX_P0_DIR: begin
                    next_p0_cfg.dir = masked_nibble(wbyte, PORT_MASK);
                end
                IDX_P1_DIR: begin
                    next_p1_cfg.dir = masked_nibble(wbyte, PORT_MASK);
                end
                IDX_P9_DIR: begin
                    next_p9_cfg.dir = masked_nibble(wbyte, P9_MASK);
                end
                IDX_P0_PU: begin
                    next_p0_cfg.pu = masked_nibble(wbyte, PORT_MASK);
                end
                IDX_P1_PU: begin
                    next_p1_cfg.pu = masked_nibble(wbyte, PORT_MASK);
                end
                IDX_P0_FSEL: begin
                    next_p0_fsel = masked_nibble(wbyte, FSEL_MASK);
                    // Giving the crystal pin back while it runs resets
                    next_osc_reset = sys_ctrl2[HF_EN_BIT]
                                     && !wbyte[HF_SEL_BIT];
                end
                IDX_P9_FSEL: begin
                    next_p9_fsel = masked_nibble(wbyte, P9_MASK);
                end
                IDX_SYS_CTRL2: begin
                    next_sys_ctrl2 = masked_nibble(wbyte, SYS_MASK);
                end
                IDX_UART_SWAP: begin
                    next_uart_swap = masked_nibble(wbyte, SWAP_MASK);
                end
                default: begin
                    // Unmapped or read-only: write ignored
                    next_osc_reset = 1'b0;
                end
            endcase
        end
    end

    // Register stage for bus and control state
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            bus_state <= BUS_IDLE;
            read_byte <= BYTE_ZERO;
            p0_cfg    <= '0;
            p1_cfg    <= '0;
            p9_cfg    <= '0;
            p0_fsel   <= REG_RESET;
            p9_fsel   <= REG_RESET;
            sys_ctrl2 <= REG_RESET;
            uart_swap <= REG_RESET;
            osc_reset <= 1'b0;
        end else begin
            bus_state <= next_bus_state;
            read_byte <= next_read_byte;
            p0_cfg    <= next_p0_cfg;
            p1_cfg    <= next_p1_cfg;
            p9_cfg    <= next_p9_cfg;
            p0_fsel   <= next_p0_fsel;
            p9_fsel   <= next_p9_fsel;
            sys_ctrl2 <= next_sys_ctrl2;
            uart_swap <= next_uart_swap;
            osc_reset <= next_osc_reset;
        end
    end

    // Secondary function ownership of pins
    always_comb begin
        hf_sel      = p0_fsel[HF_SEL_BIT];
        lf_sel      = p0_fsel[LF_SEL_BIT];
        p10_is_port = sys_ctrl2[P10_PORT_BIT];
        swap        = uart_swap[UART1_SWAP_BIT];
        // Crystal pins come in pairs: input and its return pin
        p0_own = {lf_sel, lf_sel, hf_sel, hf_sel};
        // P10 stays a reset input until software claims it
        p1_own = {3'b000, !p10_is_port};
        // Transmit needs both select and output direction
        if (swap) begin
            p9_own = {2'b00, p9_fsel[1] & p9_cfg.dir[1], 1'b0};
        end else begin
            p9_own = {3'b000, p9_fsel[0] & p9_cfg.dir[0]};
        end
        p9_tx_out = {4{uart1_transmit}};
    end

    // P0 pads; oscillator pins are never driven digitally
    gpio_pad_ctrl u_p0_pad (
        .cfg      (p0_cfg),
        .pin_in   (p0_pin_in),
        .alt_own  (p0_own),
        .alt_oe   (4'h0),
        .alt_out  (4'h0),
        .rd_block (p0_own),
        .pad      (p0_pad),
        .readback (p0_read)
    );

    // P1 pads; reset input blocks drive but not readback
    gpio_pad_ctrl u_p1_pad (
        .cfg      (p1_cfg),
        .pin_in   (p1_pin_in),
        .alt_own  (p1_own),
        .alt_oe   (4'h0),
        .alt_out  (4'h0),
        .rd_block (4'h0),
        .pad      (p1_pad),
        .readback (p1_read)
    );

    // P9 pads; top lane unused, its settings stay zero
    gpio_pad_ctrl u_p9_pad (
        .cfg      (p9_cfg),
        .pin_in   ({1'b0, p9_pin_in}),
        .alt_own  (p9_own),
        .alt_oe   (4'hf),
        .alt_out  (p9_tx_out),
        .rd_block (4'h0),
        .pad      (p9_pad),
        .readback (p9_read)
    );

    // Pin and secondary function outputs
    always_comb begin
        p0_pin_out      = p0_pad.out;
        p0_pin_oe       = p0_pad.oe;
        p0_pin_pullup   = p0_pad.pull;
        p1_pin_out      = p1_pad.out;
        p1_pin_oe       = p1_pad.oe;
        p1_pin_pullup   = p1_pad.pull;
        p9_pin_out      = p9_pad.out[2:0];
        p9_pin_oe       = p9_pad.oe[2:0];
        avs_readdata    = {24'h000000, read_byte};
        sysclk_reset_req = osc_reset;
        // Oscillator inputs idle low when not routed
        hf_osc_input    = hf_sel & p0_pin_in[0];
        lf_osc_input    = lf_sel & p0_pin_in[2];
        // Reset input idles high once P10 is a port
        external_reset_in_n = p10_is_port | p1_pin_in[0];
        // Interrupt and stop inputs idle high in output mode
        ext_irq5_in_n     = p1_cfg.dir[1] | p1_pin_in[1];
        stop_release_in_n = p1_cfg.dir[1] | p1_pin_in[1];
        // Receive pin is the one not transmitting; idle high if driven
        if (swap) begin
            uart1_receive = p9_cfg.dir[0] | p9_pin_in[0];
        end else begin
            uart1_receive = p9_cfg.dir[1] | p9_pin_in[1];
        end
    end

endmodule
`default_nettype wire

// ==== test/gpio_pin_world.sv ====
// Pad model for one port: device drive, far-side drive, pull-up.
// Assumes the bench changes ext_en and ext_val just after clock edges.
`timescale 1ns/1ps
`default_nettype none
module gpio_pin_world #(
    parameter int W = 4
) (
    input  wire logic         ref_clk,
    input  wire logic [W-1:0] out,
    input  wire logic [W-1:0] oe,
    input  wire logic [W-1:0] pull,
    input  wire logic [W-1:0] ext_en,
    input  wire logic [W-1:0] ext_val,
    output logic [W-1:0]      level
);
    // Floating pins flip each cycle so a stale level never passes
    logic [W-1:0] drift;
    initial drift = '0;
    always @(posedge ref_clk) drift <= ~drift;
    // Wire level per bit; the device wins a fight, as a strong driver would
    always_comb begin
        for (int i = 0; i < W; i++) begin
            if (oe[i])
                level[i] = out[i];      // Driven pin shows device output
            else if (ext_en[i])
                level[i] = ext_val[i];  // Far side drives
            else if (pull[i])
                level[i] = 1'b1;        // Pull-up only when released
            else
                level[i] = drift[i];    // Truly floating
        end
    end
endmodule
`default_nettype wire

// ==== test/gpio_ports_chk.sv ====
// Concurrent checks on the port block's top-level pins.
// Assumes one clock domain and the active-low rstn port.
`timescale 1ns/1ps
`default_nettype none
module gpio_ports_chk
    import gpio_port_pkg::*;
(
    input  wire logic              ref_clk,
    input  wire logic              rstn,
    input  wire logic [ADDR_W-1:0] avs_address,
    input  wire logic              avs_read,
    input  wire logic              avs_write,
    input  wire logic [DATA_W-1:0] avs_writedata,
    input  wire logic [3:0]        avs_byteenable,
    input  wire logic [DATA_W-1:0] avs_readdata,
    input  wire logic              avs_waitrequest,
    input  wire logic [3:0]        p0_pin_out,
    input  wire logic [3:0]        p0_pin_oe,
    input  wire logic [3:0]        p0_pin_pullup,
    input  wire logic [3:0]        p1_pin_in,
    input  wire logic [3:0]        p1_pin_oe,
    input  wire logic [3:0]        p1_pin_pullup,
    input  wire logic              hf_osc_input,
    input  wire logic              lf_osc_input,
    input  wire logic              sysclk_reset_req
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rstn);
    // Word index and completing write, shared by several checks
    logic [IDX_W-1:0] idx;
    logic             wr_done;
    assign idx     = avs_address[ADDR_W-1:2];
    assign wr_done = avs_write && !avs_waitrequest && avs_byteenable[0];

    chk_wait_one: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("access held more than one wait state");
    chk_wait_first: assert property ((avs_read || avs_write) && !avs_waitrequest |-> $past(avs_waitrequest))
        else $error("access completed without its wait state");
    chk_p0_latch_pin: assert property (wr_done && idx == IDX_P0_LATCH |=>
        (p0_pin_out & p0_pin_oe) == ($past(avs_writedata[3:0]) & p0_pin_oe))
        else $error("written latch not on driven pins next cycle");
    chk_p1_dir_oe: assert property (wr_done && idx == IDX_P1_DIR |=>
        p1_pin_oe[3:1] == $past(avs_writedata[3:1]))
        else $error("direction write not on output enables");
    chk_p1_readback: assert property (avs_read && !avs_waitrequest && idx == IDX_P1_READ |->
        avs_readdata[3:1] == $past(p1_pin_in[3:1] & ~p1_pin_oe[3:1]))
        else $error("pin readback not gated by direction");
    chk_pull_input: assert property (((p0_pin_pullup & p0_pin_oe) | (p1_pin_pullup & p1_pin_oe)) == 4'h0)
        else $error("pull-up on a driven pin");
    chk_upper_zero: assert property (avs_readdata[DATA_W-1:4] == '0)
        else $error("unimplemented read bits not zero");
    chk_osc_owns: assert property ((hf_osc_input || lf_osc_input) |->
        (p0_pin_oe & {{2{lf_osc_input}}, {2{hf_osc_input}}}) == 4'h0)
        else $error("routed oscillator pin still driven");
    chk_reset_pulse: assert property (sysclk_reset_req |->
        $past(wr_done && idx == IDX_P0_FSEL && !avs_writedata[0]) ##1 !sysclk_reset_req)
        else $error("clock reset request without cause or too long");
endmodule
bind gpio_ports gpio_ports_chk chk (.ref_clk, .rstn, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .p0_pin_out, .p0_pin_oe,
    .p0_pin_pullup, .p1_pin_in, .p1_pin_oe, .p1_pin_pullup, .hf_osc_input, .lf_osc_input,
    .sysclk_reset_req);
`default_nettype wire

// ==== test/test_gpio_ports.sv ====
// Self-checking bench for the P0/P1/P9 port block.
// Assumes the pad models in gpio_pin_world and the bound checker.
`timescale 1ns/1ps
`default_nettype none
`define CHECK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin miscompares++; \
    $display("CHECK FAILED %s exp=%0h got=%0h", nm, e, g); end end
module test_gpio_ports
    import gpio_port_pkg::*;
;
    logic              ref_clk, rstn, avs_read, avs_write, avs_waitrequest, tx, rx;
    logic [ADDR_W-1:0] avs_address;
    logic [DATA_W-1:0] avs_writedata, avs_readdata;
    logic [3:0]        be, p0_in, p0_out, p0_oe, p0_pu, p0_en, p0_val;
    logic [3:0]        p1_in, p1_out, p1_oe, p1_pu, p1_en, p1_val;
    logic [2:0]        p9_in, p9_out, p9_oe, p9_en, p9_val;
    logic              hf, lf, rst_in_n, irq5_n, stop_n, sreq;
    logic [7:0]        q;                  // Last read byte
    int                miscompares, cmp_count, cyc, pulses;

    gpio_ports uut (.ref_clk(ref_clk), .rstn(rstn), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(be), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .p0_pin_in(p0_in), .p0_pin_out(p0_out), .p0_pin_oe(p0_oe), .p0_pin_pullup(p0_pu),
        .p1_pin_in(p1_in), .p1_pin_out(p1_out), .p1_pin_oe(p1_oe), .p1_pin_pullup(p1_pu),
        .p9_pin_in(p9_in), .p9_pin_out(p9_out), .p9_pin_oe(p9_oe), .hf_osc_input(hf),
        .lf_osc_input(lf), .external_reset_in_n(rst_in_n), .ext_irq5_in_n(irq5_n),
        .stop_release_in_n(stop_n), .uart1_transmit(tx), .uart1_receive(rx),
        .sysclk_reset_req(sreq));
    // Pads of the three ports; P9 has no pull-ups
    gpio_pin_world #(.W(4)) w0 (.ref_clk(ref_clk), .out(p0_out), .oe(p0_oe), .pull(p0_pu),
        .ext_en(p0_en), .ext_val(p0_val), .level(p0_in));
    gpio_pin_world #(.W(4)) w1 (.ref_clk(ref_clk), .out(p1_out), .oe(p1_oe), .pull(p1_pu),
        .ext_en(p1_en), .ext_val(p1_val), .level(p1_in));
    gpio_pin_world #(.W(3)) w9 (.ref_clk(ref_clk), .out(p9_out), .oe(p9_oe), .pull(3'h0),
        .ext_en(p9_en), .ext_val(p9_val), .level(p9_in));

    // 50 MHz clock
    initial begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end
    // Pulse counter and hang guard; the run needs well under 2000 cycles
    always @(posedge ref_clk) begin
        cyc++;
        if (sreq === 1'b1)
            pulses++;
        if (cyc == 5000) begin
            miscompares++;
            test_done();
        end
    end

    // One bus access; waits for waitrequest low, takes data at that edge
    task automatic bus(input logic w, input logic [IDX_W-1:0] ix, input logic [7:0] d);
        @(posedge ref_clk);
        avs_address   <= {ix, 2'b00};
        avs_writedata <= {24'h0, d};
        avs_write     <= w;
        avs_read      <= !w;
        do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
        q = avs_readdata[7:0];
        avs_write <= 1'b0;
        avs_read  <= 1'b0;
    endtask
    // Read and compare
    task automatic rdc(input logic [IDX_W-1:0] ix, input logic [7:0] e);
        bus(1'b0, ix, 8'h00);
        `CHECK("readdata", e, q)
    endtask

    // Reset values, refused writes, unmapped place
    task automatic t_reset();
        logic [IDX_W-1:0] ixs [8] = '{IDX_P0_LATCH, IDX_P1_LATCH, IDX_P0_DIR, IDX_P1_DIR,
                                      IDX_P0_PU, IDX_P1_PU, IDX_P0_FSEL, 12'h123};
        `CHECK("oe_pull", 16'h0, {p0_oe, p1_oe, p0_pu, p1_pu})
        be <= 4'h0;
        bus(1'b1, IDX_P0_LATCH, 8'hff);
        be <= 4'h1;
        bus(1'b1, 12'h123, 8'hff);
        foreach (ixs[i]) rdc(ixs[i], 8'h00);
        $display("t_reset done");
    endtask
    // P0 mixed directions, latch hold, gated readback
    task automatic t_p0_out();
        p0_en  <= 4'hc;
        p0_val <= 4'h4;
        bus(1'b1, IDX_P0_DIR, 8'hf3);
        bus(1'b1, IDX_P0_LATCH, 8'h5a);
        @(negedge ref_clk);
        `CHECK("p0_oe", 4'h3, p0_oe)
        `CHECK("p0_out", 4'h2, p0_out & p0_oe)
        rdc(IDX_P0_LATCH, 8'h0a);
        rdc(IDX_P0_READ, 8'h04);
        bus(1'b1, IDX_P0_DIR, 8'h0f);
        @(negedge ref_clk);
        `CHECK("p0_out", 4'ha, p0_out)
        $display("t_p0_out done");
    endtask
    // P1 reset pin handover, pull-ups, secondary inputs, readback
    task automatic t_p1_in();
        p1_en  <= 4'hf;
        p1_val <= 4'h2;
        @(negedge ref_clk);
        `CHECK("reset_in", 1'b0, rst_in_n)
        bus(1'b1, IDX_SYS_CTRL2, 8'h02);
        bus(1'b1, IDX_P1_DIR, 8'h05);
        bus(1'b1, IDX_P1_PU, 8'h0f);
        p1_val <= 4'h8;
        @(negedge ref_clk);
        `CHECK("reset_in", 1'b1, rst_in_n)
        `CHECK("p1_pullup", 4'ha, p1_pu)
        `CHECK("p1_out", 4'h0, p1_out)
        `CHECK("irq_stop", 2'b00, {irq5_n, stop_n})
        rdc(IDX_P1_READ, 8'h08);
        $display("t_p1_in done");
    endtask
    // Oscillator routing and the clock reset request
    task automatic t_osc();
        p0_val <= 4'h5;
        p0_en  <= 4'hf;
        bus(1'b1, IDX_P0_PU, 8'h0f);
        bus(1'b1, IDX_P0_FSEL, 8'hff);
        @(negedge ref_clk);
        `CHECK("osc", 2'b11, {hf, lf})
        `CHECK("p0_oe_pu", 8'h00, {p0_oe, p0_pu})
        rdc(IDX_P0_FSEL, 8'h05);
        rdc(IDX_P0_READ, 8'h00);
        bus(1'b1, IDX_P0_FSEL, 8'h04);
        bus(1'b1, IDX_SYS_CTRL2, 8'h03);
        bus(1'b1, IDX_P0_FSEL, 8'h04);
        repeat (3) @(negedge ref_clk);
        `CHECK("reset_pulses", 1, pulses)
        `CHECK("osc", 2'b01, {hf, lf})
        $display("t_osc done");
    endtask
    // UART1 pins both ways round
    task automatic t_uart();
        p9_en  <= 3'h7;
        p9_val <= 3'h2;
        tx     <= 1'b1;
        bus(1'b1, IDX_P9_FSEL, 8'h01);
        bus(1'b1, IDX_P9_DIR, 8'h01);
        @(negedge ref_clk);
        `CHECK("p9_tx_rx", 3'h7, {p9_oe[0], p9_out[0], rx})
        bus(1'b1, IDX_UART_SWAP, 8'h01);
        bus(1'b1, IDX_P9_FSEL, 8'h02);
        bus(1'b1, IDX_P9_DIR, 8'h02);
        p9_val <= 3'h1;
        tx     <= 1'b0;
        @(negedge ref_clk);
        `CHECK("p9_tx_rx", 3'h5, {p9_oe[1], p9_out[1], rx})
        $display("t_uart done");
    endtask

    // Counts and verdict
    task automatic test_done();
        $display("compares=%0d mismatches=%0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // Main sequence
    initial begin
        rstn = 1'b0;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_address = '0;
        avs_writedata = '0;
        be = 4'h1;
        tx = 1'b0;
        {p0_en, p0_val, p1_en, p1_val} = '0;
        {p9_en, p9_val} = '0;
        repeat (12) @(posedge ref_clk);
        rstn <= 1'b1;
        repeat (3) @(posedge ref_clk);
        t_reset();
        t_p0_out();
        t_p1_in();
        t_osc();
        t_uart();
        test_done();
    end
endmodule
`default_nettype wire
